// *** verilog/port_defs.svh ***
`ifndef PORT_DEFS_SVH
`define PORT_DEFS_SVH

// Register offsets
`define ADDR_PIN_DATA    8'h00
`define ADDR_PIN_DIR     8'h01
`define ADDR_DATA_SET    8'h02
`define ADDR_DATA_CLEAR  8'h03
`define ADDR_ANALOG_SEL  8'h04
`define ADDR_PORT_CFG    8'h05

// Reset values
`define DATA_RESET       6'h00
`define DIR_RESET        6'h3F
`define ANALOG_RESET     6'h3F
`define RDATA_IDLE       8'h00
`define PINS_IDLE        6'h00
`define EXT_RESET_IDLE   1'h0

// Field positions and masks
`define PIN_THREE        3
`define CFG_EXT_RESET    0
`define CFG_OSC_LO       1
`define CFG_OSC_HI       2
`define MASK_PIN_THREE   6'h08
`define MASK_XTAL_PINS   6'h30
`define UPPER_ZERO       2'h0
`define UPPER_CFG_ZERO   5'h00
`define XTAL_DIR_READ    2'h3

`endif

// *** verilog/port_pkg.sv ***
`default_nettype none
package port_pkg;

	typedef logic [5:0] pin_vec_t;

	typedef enum logic [1:0] {
		OSC_INTERNAL = 2'h0,
		OSC_LP       = 2'h1,
		OSC_XT       = 2'h2,
		OSC_HS       = 2'h3
	} osc_mode_t;

endpackage
`default_nettype wire

// *** verilog/six_bit_bidirectional_port.sv ***
// Our own choices: the address map and the plain strobed port.
`include "port_defs.svh"
`default_nettype none

module six_bit_bidirectional_port (
	input  wire logic               clock,
	input  wire logic               reset_n,
	input  wire logic [7:0]         addr,
	input  wire logic [7:0]         wdata,
	input  wire logic               wr_stb,
	input  wire logic               rd_stb,
	output var  logic [7:0]         rdata,
	input  wire port_pkg::pin_vec_t pin_in,
	output var  port_pkg::pin_vec_t pin_out,
	output var  port_pkg::pin_vec_t pin_oe,
	input  wire port_pkg::pin_vec_t periph_en,
	input  wire port_pkg::pin_vec_t periph_out,
	input  wire port_pkg::pin_vec_t periph_oe,
	output var  port_pkg::pin_vec_t pin_change
);
	import port_pkg::*;

	pin_vec_t  latch_r;
	pin_vec_t  latch_nxt;
	pin_vec_t  dir_r;
	pin_vec_t  dir_nxt;
	pin_vec_t  analog_r;
	pin_vec_t  analog_nxt;
	logic      ext_reset_en_r;
	logic      ext_reset_en_nxt;
	osc_mode_t osc_mode_r;
	osc_mode_t osc_mode_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	pin_vec_t  pin_out_r;
	pin_vec_t  pin_out_nxt;
	pin_vec_t  pin_oe_r;
	pin_vec_t  pin_oe_nxt;
	pin_vec_t  pin_prev_r;
	pin_vec_t  pin_change_r;
	pin_vec_t  pin_change_nxt;

	// Address decode
	wire sel_data_wr = wr_stb && (addr == `ADDR_PIN_DATA);
	wire sel_dir_wr  = wr_stb && (addr == `ADDR_PIN_DIR);
	wire sel_set_wr  = wr_stb && (addr == `ADDR_DATA_SET);
	wire sel_clr_wr  = wr_stb && (addr == `ADDR_DATA_CLEAR);
	wire sel_ana_wr  = wr_stb && (addr == `ADDR_ANALOG_SEL);
	wire sel_cfg_wr  = wr_stb && (addr == `ADDR_PORT_CFG);

	// Pin three is always held as input, the oscillator pins in the LP, XT and HS modes unless periph_en hands them to a peripheral
	wire xtal_mode = (osc_mode_r == OSC_LP) || (osc_mode_r == OSC_XT)
		|| (osc_mode_r == OSC_HS);
	wire pin_vec_t forced_in = `MASK_PIN_THREE
		| (xtal_mode ? `MASK_XTAL_PINS : `PINS_IDLE);
	wire pin_vec_t dir_eff = dir_r | forced_in;

	// Pin levels as software sees them
	wire pin_vec_t three_hide = ext_reset_en_r ? `MASK_PIN_THREE
		: `PINS_IDLE;
	wire pin_vec_t pin_read = pin_in & ~analog_r & ~three_hide;

	// Bit merge: set and clear offsets touch only the bits named in wdata,
	// the rest come from the pins as sampled now, so a pin held low by a
	// load can overwrite its latch bit. That is the price of the RMW.
	wire pin_vec_t wr_bits = wdata[5:0];
	wire pin_vec_t merge_set = pin_read | wr_bits;
	wire pin_vec_t merge_clr = pin_read & ~wr_bits;

	assign latch_nxt = sel_data_wr ? wr_bits
		: sel_set_wr ? merge_set
		: sel_clr_wr ? merge_clr
		: latch_r;

	assign dir_nxt = sel_dir_wr ? wr_bits : dir_r;
	assign analog_nxt = sel_ana_wr ? wr_bits : analog_r;
	assign ext_reset_en_nxt = sel_cfg_wr ? wdata[`CFG_EXT_RESET]
		: ext_reset_en_r;
	assign osc_mode_nxt = sel_cfg_wr
		? osc_mode_t'(wdata[`CFG_OSC_HI:`CFG_OSC_LO]) : osc_mode_r;

	// Drivers: analog select does not enter here on purpose
	wire pin_vec_t gpio_drive = ~periph_en & ~dir_eff;
	wire pin_vec_t periph_drive = periph_en & periph_oe;
	assign pin_oe_nxt = (gpio_drive | periph_drive)
		& ~`MASK_PIN_THREE;
	assign pin_out_nxt = ((periph_en & periph_out)
		| (~periph_en & latch_nxt)) & ~`MASK_PIN_THREE;

	// Change events feed an interrupt controller elsewhere
	assign pin_change_nxt = (pin_in ^ pin_prev_r) & ~analog_r;

	// Read mux, answered one cycle after the strobe
	wire [7:0] data_view = {`UPPER_ZERO, pin_read};
	wire [7:0] dir_view = {`UPPER_ZERO, dir_eff};
	wire [7:0] ana_view = {`UPPER_ZERO, analog_r};
	wire [7:0] cfg_view = {`UPPER_CFG_ZERO, osc_mode_r, ext_reset_en_r};
	wire [7:0] read_mux =
		(addr == `ADDR_PIN_DATA)   ? data_view :
		(addr == `ADDR_PIN_DIR)    ? dir_view :
		(addr == `ADDR_ANALOG_SEL) ? ana_view :
		(addr == `ADDR_PORT_CFG)   ? cfg_view :
		`RDATA_IDLE;
	assign rdata_nxt = rd_stb ? read_mux : `RDATA_IDLE;

	// Latch bits 5 and 3 are unknown after reset; zero is chosen
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			latch_r  <= `DATA_RESET;
			dir_r    <= `DIR_RESET;
			analog_r <= `ANALOG_RESET;
		end else begin
			latch_r  <= latch_nxt;
			dir_r    <= dir_nxt;
			analog_r <= analog_nxt;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ext_reset_en_r <= `EXT_RESET_IDLE;
			osc_mode_r     <= OSC_INTERNAL;
		end else begin
			ext_reset_en_r <= ext_reset_en_nxt;
			osc_mode_r     <= osc_mode_nxt;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pin_out_r <= `PINS_IDLE;
			pin_oe_r  <= `PINS_IDLE;
			rdata_r   <= `RDATA_IDLE;
		end else begin
			pin_out_r <= pin_out_nxt;
			pin_oe_r  <= pin_oe_nxt;
			rdata_r   <= rdata_nxt;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pin_prev_r   <= `PINS_IDLE;
			pin_change_r <= `PINS_IDLE;
		end else begin
			pin_prev_r   <= pin_in;
			pin_change_r <= pin_change_nxt;
		end
	end

	assign rdata      = rdata_r;
	assign pin_out    = pin_out_r;
	assign pin_oe     = pin_oe_r;
	assign pin_change = pin_change_r;

	// Checks

	a_input_no_drive:
	assert property (@(posedge clock) disable iff (!reset_n)
		(~periph_en & dir_eff) != `PINS_IDLE
		|=> (pin_oe & $past(~periph_en & dir_eff)) == `PINS_IDLE)
	else $error("input pin is driven");

	a_output_drives_latch:
	assert property (@(posedge clock) disable iff (!reset_n)
		gpio_drive != `PINS_IDLE
		|=> ((pin_oe & $past(gpio_drive & ~`MASK_PIN_THREE))
			== $past(gpio_drive & ~`MASK_PIN_THREE))
		&& (((pin_out ^ latch_r) & $past(gpio_drive)) == `PINS_IDLE))
	else $error("output pin not driving latch");

	a_pin_three_input:
	assert property (@(posedge clock) disable iff (!reset_n)
		rd_stb && (addr == `ADDR_PIN_DIR)
		|=> rdata[`PIN_THREE] && !pin_oe[`PIN_THREE])
	else $error("pin three not input only");

	a_data_read_pins:
	assert property (@(posedge clock) disable iff (!reset_n)
		rd_stb && (addr == `ADDR_PIN_DATA)
		|=> rdata[5:0] == $past(pin_read))
	else $error("data read differs from pins");

	a_set_merges_pins:
	assert property (@(posedge clock) disable iff (!reset_n)
		sel_set_wr |=> latch_r == ($past(pin_read) | $past(wr_bits)))
	else $error("set write not merged with pins");

	a_clear_merges_pins:
	assert property (@(posedge clock) disable iff (!reset_n)
		sel_clr_wr |=> latch_r == ($past(pin_read) & ~$past(wr_bits)))
	else $error("clear write not merged with pins");

	a_ext_reset_hides:
	assert property (@(posedge clock) disable iff (!reset_n)
		rd_stb && (addr == `ADDR_PIN_DATA) && ext_reset_en_r
		|=> !rdata[`PIN_THREE])
	else $error("pin three visible with reset pin on");

	a_analog_reads_zero:
	assert property (@(posedge clock) disable iff (!reset_n)
		rd_stb && (addr == `ADDR_PIN_DATA)
		|=> (rdata[5:0] & $past(analog_r)) == `PINS_IDLE)
	else $error("analog pin read nonzero");

	a_analog_no_event:
	assert property (@(posedge clock) disable iff (!reset_n)
		1'b1 |=> (pin_change & $past(analog_r)) == `PINS_IDLE)
	else $error("analog pin raised change event");

	a_upper_bits_zero:
	assert property (@(posedge clock) disable iff (!reset_n)
		rd_stb |=> rdata[7:6] == `UPPER_ZERO)
	else $error("unimplemented bits read nonzero");

	a_xtal_dir_read:
	assert property (@(posedge clock) disable iff (!reset_n)
		rd_stb && (addr == `ADDR_PIN_DIR) && xtal_mode
		|=> rdata[5:4] == `XTAL_DIR_READ)
	else $error("crystal pins not read as inputs");

	a_periph_owns_pin:
	assert property (@(posedge clock) disable iff (!reset_n)
		periph_en != `PINS_IDLE
		|=> ((pin_out ^ $past(periph_out))
			& $past(periph_en & ~`MASK_PIN_THREE)) == `PINS_IDLE)
	else $error("peripheral lost its pin");

	a_latch_retained:
	assert property (@(posedge clock) disable iff (!reset_n)
		!(sel_data_wr || sel_set_wr || sel_clr_wr)
		|=> $stable(latch_r))
	else $error("latch changed without a write");

	a_read_one_cycle:
	assert property (@(posedge clock) disable iff (!reset_n)
		!rd_stb |=> rdata == `RDATA_IDLE)
	else $error("read data outside answer cycle");

	a_pin_three_quiet:
	assert property (@(posedge clock) disable iff (!reset_n)
		!pin_oe[`PIN_THREE] && !pin_out[`PIN_THREE])
	else $error("pin three driven");

	a_dir_write_lands:
	assert property (@(posedge clock) disable iff (!reset_n)
		sel_dir_wr |=> dir_r == $past(wr_bits))
	else $error("direction write lost");

	a_data_write_lands:
	assert property (@(posedge clock) disable iff (!reset_n)
		sel_data_wr |=> latch_r == $past(wr_bits))
	else $error("data write lost");

	a_set_bits_high:
	assert property (@(posedge clock) disable iff (!reset_n)
		sel_set_wr |=> (latch_r & $past(wr_bits)) == $past(wr_bits))
	else $error("set bit not stored");

	a_clear_bits_low:
	assert property (@(posedge clock) disable iff (!reset_n)
		sel_clr_wr |=> (latch_r & $past(wr_bits)) == `PINS_IDLE)
	else $error("clear bit not stored");

	a_analog_keeps_drive:
	assert property (@(posedge clock) disable iff (!reset_n)
		(analog_r & gpio_drive) != `PINS_IDLE
		|=> (pin_oe & $past(analog_r & gpio_drive))
			== $past(analog_r & gpio_drive))
	else $error("analog select cut a driver");

	a_pin_three_visible:
	assert property (@(posedge clock) disable iff (!reset_n)
		rd_stb && (addr == `ADDR_PIN_DATA) && !ext_reset_en_r
		&& !analog_r[`PIN_THREE]
		|=> rdata[`PIN_THREE] == $past(pin_in[`PIN_THREE]))
	else $error("pin three level not read");

	a_dir_read_value:
	assert property (@(posedge clock) disable iff (!reset_n)
		rd_stb && (addr == `ADDR_PIN_DIR) && !xtal_mode
		|=> rdata[5:0] == ($past(dir_r) | `MASK_PIN_THREE))
	else $error("direction read wrong");

	a_xtal_pins_quiet:
	assert property (@(posedge clock) disable iff (!reset_n)
		xtal_mode
		|=> (pin_oe & $past(`MASK_XTAL_PINS & ~periph_en)) == `PINS_IDLE)
	else $error("crystal pin driven");

endmodule // six_bit_bidirectional_port
`default_nettype wire

// *** verif/pin_model.sv ***
`default_nettype none
module pin_model (
	input  wire logic               clock,
	input  wire port_pkg::pin_vec_t pin_out,
	input  wire port_pkg::pin_vec_t pin_oe,
	input  wire port_pkg::pin_vec_t ext_val,
	input  wire port_pkg::pin_vec_t ext_en,
	output var  port_pkg::pin_vec_t pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	import port_pkg::*;
	pin_vec_t flt_r = 6'h00;
	// Undriven lines wander, so a stale level never passes for a read
	always @(posedge clock) begin
		flt_r <= ~pin_in;
	end
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en & flt_r);
endmodule // pin_model
`default_nettype wire

// *** verif/six_bit_bidirectional_port_tb.sv ***
`include "port_defs.svh"
`default_nettype none
module six_bit_bidirectional_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import port_pkg::*;
	logic        clock = 1'b0, reset_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, d;
	pin_vec_t    pin_in, pin_out, pin_oe, pin_change, dv, lv, e, acc;
	pin_vec_t    ext_val = 6'h00, ext_en = 6'h3F, periph_en = 6'h00;
	pin_vec_t    periph_out = 6'h00, periph_oe = 6'h00;
	int          n_errors = 0, check_count = 0;
	logic [31:0] seed = 32'h24;
	always #12.5 clock = ~clock;
	six_bit_bidirectional_port dut (.clock(clock), .reset_n(reset_n),
		.addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.periph_en(periph_en), .periph_out(periph_out),
		.periph_oe(periph_oe), .pin_change(pin_change));
	pin_model pins (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
		.ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
	function automatic pin_vec_t rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return pin_vec_t'(seed);
	endfunction
	function automatic pin_vec_t drv(pin_vec_t dir, logic xtal);
		return ~dir & ~`MASK_PIN_THREE & ~(xtal ? `MASK_XTAL_PINS : 6'h00);
	endfunction
	task automatic chk(string n, logic [7:0] x, logic [7:0] g);
		check_count++;
		if (g !== x) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", n, x, g);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] v);
		@(posedge clock);
		addr <= a;
		wdata <= v;
		wr_stb <= 1'b1;
		@(posedge clock);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a);
		@(posedge clock);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clock);
		rd_stb <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		n_errors++;
		give_verdict();
	end
	initial begin
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		tick(1);
		chk("oe", 8'h00, {2'h0, pin_oe});
		rd(`ADDR_PIN_DIR);
		chk("dir", 8'h3F, d);
		@(posedge clock);
		ext_val <= 6'h3F;
		rd(`ADDR_PIN_DATA);
		chk("analog rd", 8'h00, d);
		wr(`ADDR_ANALOG_SEL, 8'h00);
		rd(`ADDR_PIN_DATA);
		chk("data", 8'h3F, d);
		rd(8'h3A);
		chk("unmapped", 8'h00, d);
		for (int i = 0; i < 24; i++) begin
			dv = rnd();
			lv = rnd();
			e = rnd();
			wr(`ADDR_PIN_DIR, {2'h0, dv});
			wr(`ADDR_PIN_DATA, {2'h0, lv});
			ext_val <= e;
			tick(1);
			chk("oe", {2'h0, drv(dv, 1'b0)}, {2'h0, pin_oe});
			chk("out", {2'h0, lv & drv(dv, 1'b0)}, {2'h0, pin_out & pin_oe});
			rd(`ADDR_PIN_DATA);
			chk("pins", {2'h0, (lv & drv(dv, 1'b0)) | (e & ~drv(dv, 1'b0))}, d);
			rd(`ADDR_PIN_DIR);
			chk("dir rd", {2'h0, dv | `MASK_PIN_THREE}, d);
			// Merge sees the pins, not the latch, while all are inputs
			wr(`ADDR_PIN_DIR, 8'h3F);
			wr(i % 2 ? `ADDR_DATA_SET : `ADDR_DATA_CLEAR, {2'h0, dv});
			wr(`ADDR_PIN_DIR, 8'h00);
			tick(1);
			chk("rmw", {2'h0, (i % 2 ? e | dv : e & ~dv) & 6'h37},
				{2'h0, pin_out & pin_oe});
		end
		wr(`ADDR_ANALOG_SEL, 8'h3F);
		ext_en <= 6'h00;
		for (int m = 0; m < 4; m++) begin
			wr(`ADDR_PORT_CFG, {5'h00, m[1:0], 1'b0});
			tick(1);
			chk("xtal oe", {2'h0, drv(6'h00, m != 0)}, {2'h0, pin_oe});
			rd(`ADDR_PIN_DIR);
			chk("xtal dir", m != 0 ? 8'h38 : 8'h08, d);
			rd(`ADDR_PIN_DATA);
			chk("analog", 8'h00, d);
		end
		wr(`ADDR_PIN_DIR, 8'h3F);
		wr(`ADDR_ANALOG_SEL, 8'h01);
		wr(`ADDR_PORT_CFG, 8'h01);
		ext_en <= 6'h3F;
		ext_val <= 6'h3F;
		rd(`ADDR_PIN_DATA);
		chk("ext reset", 8'h36, d);
		acc = 6'h00;
		@(posedge clock);
		ext_val <= 6'h3C;
		repeat (3) begin
			tick(1);
			acc |= pin_change;
		end
		chk("change", 8'h02, {2'h0, acc});
		@(posedge clock);
		periph_en <= 6'h01;
		periph_oe <= 6'h01;
		periph_out <= 6'h01;
		tick(2);
		chk("periph", 8'h01, {2'h0, pin_oe & pin_out});
		@(posedge clock);
		reset_n <= 1'b0;
		periph_en <= 6'h00;
		tick(2);
		chk("reset oe", 8'h00, {2'h0, pin_oe});
		@(posedge clock);
		reset_n <= 1'b1;
		rd(`ADDR_PIN_DIR);
		chk("reset dir", 8'h3F, d);
		rd(`ADDR_ANALOG_SEL);
		chk("reset analog", 8'h3F, d);
		rd(`ADDR_PORT_CFG);
		chk("reset cfg", 8'h00, d);
		wr(`ADDR_PIN_DIR, 8'h00);
		tick(1);
		chk("reset latch", 8'h00, {2'h0, pin_out & pin_oe & 6'h17});
		give_verdict();
	end
endmodule // six_bit_bidirectional_port_tb
`default_nettype wire
